// ===== logic/plhi_block.sv
// Block end: one pass reads inputs, uses the RAM and writes outputs.
// How it works
// (RL1) Bare data ports carry data only.
// (RL2) Bare input producer holds data during transaction.
// (RL3) Bare output consumer samples at right cycle.
// (RL4) Config input steady while block runs; far end holds cfg_data only while block_go high.
// (RL5) Config input only, fanout not registered.
// (RL6) Control names are data name plus suffix.
// (RL7) No handshake before block_go starts operation.
// (RL8) Handshake input stalls while valid low.
// (RL9) Acknowledge pulses when valid input taken.
// (RL10) Output valid rises with new data.
// (RL11) Hold data and valid while acknowledge low.
// (RL12) Drop output valid edge after acknowledge.
// (RL13) Ack-only input acknowledges in consuming cycle.
// (RL14) Ack-only output stalls until acknowledge high.
// (RL15) Valid-only input captured whenever valid active.
// (RL16) Valid-only output valid marks data cycles.
// (RL17) Output-valid-only: bare inputs, valid outputs.
// (RL18) RAM protocol same discrete or grouped.
// (RL19) Read drives address with chip enable.
// (RL20) RAM returns read data after latency.
// (RL21) Write drives ce, we, address, data together.
// (RL22) Producer holds data until acknowledge.
// (RL23) Controller raises block_go before port activity.
`timescale 1ns/100ps
module plhi_block
	import plhi_pkg::*;
	#(
	parameter int RAM_LAT = PLHI_RAM_LAT
	)
	(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Link to far side.
	plhi_if.blk lnk,
	// User-side status.
	output logic busy,
	output logic pass_done
	);

	plhi_state_t st_r;
	plhi_state_t st_nxt;
	logic [PLHI_DATA_W-1:0] acc_r;
	logic [PLHI_DATA_W-1:0] vo_hold_r;
	logic [PLHI_DATA_W-1:0] out_r;
	logic [PLHI_DATA_W-1:0] bare_out_r;
	logic [PLHI_ADDR_W-1:0] addr_r;
	logic [3:0] lat_r;
	logic hs_out_vld_r;
	logic vo_out_vld_r;
	logic done_r;

	// The step that takes the handshake input waits on its valid.
	wire take_in = (st_r == PLHI_GET) && lnk.hs_in_vld; // [RL8]
	wire put_done = (st_r == PLHI_PUT) && lnk.hs_out_ack;
	wire ao_done = (st_r == PLHI_ACKOUT) && lnk.ao_out_ack; // [RL14]
	wire rd_back = (st_r == PLHI_RWAIT) && (lat_r == 4'h0); // [RL20]

	// Ports move only after operation starts.
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			PLHI_IDLE: if (lnk.block_go) st_nxt = PLHI_GET; // [RL7] [RL23]
			PLHI_GET: if (take_in) st_nxt = PLHI_RD;
			PLHI_RD: st_nxt = PLHI_RWAIT;
			PLHI_RWAIT: if (rd_back) st_nxt = PLHI_WR;
			PLHI_WR: st_nxt = PLHI_PUT;
			PLHI_PUT: if (put_done) st_nxt = PLHI_ACKOUT; // [RL11]
			PLHI_ACKOUT: if (ao_done) st_nxt = PLHI_IDLE;
			default: st_nxt = PLHI_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st_r <= PLHI_IDLE;
		else
			st_r <= st_nxt;
	end

	// Valid-only input is caught even while busy elsewhere.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			vo_hold_r <= PLHI_DATA_RST;
		else if (lnk.vo_in_vld)
			vo_hold_r <= lnk.vo_in; // [RL15]
	end

	// Read latency counter; a longer RAM only changes RAM_LAT.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			lat_r <= 4'h0;
		else if (st_r == PLHI_RD)
			lat_r <= 4'(RAM_LAT - 1);
		else if (lat_r != 4'h0)
			lat_r <= lat_r - 4'h1;
	end

	// Datapath: config is read straight, never registered first.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			acc_r <= PLHI_DATA_RST;
			addr_r <= PLHI_ADDR_RST;
			out_r <= PLHI_DATA_RST;
		end
		else
		begin
			if (take_in)
				acc_r <= lnk.hs_in + lnk.cfg_data + lnk.bare_in; // [RL5] [RL2]
			if (rd_back)
				acc_r <= acc_r + lnk.ram_read_data + lnk.ao_in + vo_hold_r;
			if (st_r == PLHI_WR)
			begin
				out_r <= acc_r;
				addr_r <= addr_r + 6'h01;
			end
		end
	end

	// Handshake output valid rises with its data and falls after acknowledge; valid-only output valid lasts one cycle.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hs_out_vld_r <= 1'b0;
			vo_out_vld_r <= 1'b0;
			bare_out_r <= PLHI_DATA_RST;
			done_r <= 1'b0;
		end
		else
		begin
			if (st_r == PLHI_WR)
				hs_out_vld_r <= 1'b1; // [RL10]
			else if (put_done)
				hs_out_vld_r <= 1'b0; // [RL12]
			vo_out_vld_r <= (st_r == PLHI_WR); // [RL16] [RL17]
			if (ao_done)
				bare_out_r <= out_r; // [RL1] [RL3]
			done_r <= ao_done;
		end
	end

	// Handshake names follow the data name with a suffix.
	assign lnk.hs_in_ack = take_in; // [RL9] [RL6] [RL22]
	assign lnk.ao_in_ack = rd_back; // [RL13]
	assign lnk.hs_out = out_r;
	assign lnk.hs_out_vld = hs_out_vld_r;
	assign lnk.ao_out = out_r;
	assign lnk.vo_out = out_r;
	assign lnk.vo_out_vld = vo_out_vld_r;
	assign lnk.bare_out = bare_out_r;
	// Same signals serve a discrete or grouped presentation.
	assign lnk.ram_addr = addr_r; // [RL18]
	assign lnk.ram_ce = (st_r == PLHI_RD) || (st_r == PLHI_WR); // [RL19] [RL21]
	assign lnk.ram_we = (st_r == PLHI_WR); // [RL21]
	assign lnk.ram_write_data = acc_r;
	assign busy = (st_r != PLHI_IDLE);
	assign pass_done = done_r;
endmodule : plhi_block

// ===== logic/plhi_far.sv
// Far end: producer, consumer and a single-port RAM.
`timescale 1ns/100ps
module plhi_far
	import plhi_pkg::*;
	#(
	parameter int DEPTH = 64
	)
	(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Link to the block.
	plhi_if.far lnk,
	// User side.
	input wire logic go,
	input wire logic [PLHI_DATA_W-1:0] cfg,
	input wire logic [PLHI_DATA_W-1:0] src_data,
	input wire logic src_vld,
	input wire logic sink_rdy,
	output logic [PLHI_DATA_W-1:0] sink_data,
	output logic sink_vld
	);

	logic [PLHI_DATA_W-1:0] mem [DEPTH];
	logic [PLHI_DATA_W-1:0] q_r;
	logic [PLHI_DATA_W-1:0] hold_r;
	logic hold_vld_r;
	logic [PLHI_DATA_W-1:0] sink_r;
	logic sink_vld_r;
	logic [PLHI_DATA_W-1:0] cfg_r;

	// RAM answers one cycle after chip enable.
	// It is cleared on reset so that a read before any write is known.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= PLHI_DATA_RST;
			q_r <= PLHI_DATA_RST;
		end
		else
		begin
			if (lnk.ram_ce && lnk.ram_we)
				mem[lnk.ram_addr] <= lnk.ram_write_data;
			if (lnk.ram_ce)
				q_r <= mem[lnk.ram_addr]; // [RL20]
		end
	end

	// Producer keeps value and valid until acknowledged; config moves while block_go is low.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hold_r <= PLHI_DATA_RST;
			hold_vld_r <= 1'b0;
			cfg_r <= PLHI_DATA_RST;
			sink_r <= PLHI_DATA_RST;
			sink_vld_r <= 1'b0;
		end
		else
		begin
			if (!hold_vld_r || lnk.hs_in_ack)
			begin
				hold_r <= src_data; // [RL22] [RL2]
				hold_vld_r <= src_vld;
			end
			if (!lnk.block_go)
				cfg_r <= cfg; // [RL4]
			sink_vld_r <= lnk.hs_out_vld && sink_rdy;
			if (lnk.hs_out_vld && sink_rdy)
				sink_r <= lnk.hs_out;
		end
	end

	assign lnk.block_go = go; // [RL23]
	assign lnk.cfg_data = cfg_r;
	assign lnk.bare_in = hold_r;
	assign lnk.hs_in = hold_r;
	assign lnk.hs_in_vld = hold_vld_r;
	assign lnk.hs_out_ack = lnk.hs_out_vld && sink_rdy;
	assign lnk.ao_in = hold_r;
	assign lnk.ao_out_ack = sink_rdy;
	assign lnk.vo_in = hold_r;
	assign lnk.vo_in_vld = hold_vld_r;
	assign lnk.ram_read_data = q_r;
	assign sink_data = sink_r;
	assign sink_vld = sink_vld_r;
endmodule : plhi_far

// ===== logic/plhi_if.sv
// Interface joining the block end and the far-side logic end.
`timescale 1ns/100ps
interface plhi_if
	import plhi_pkg::*;
	();
	logic block_go;
	logic [PLHI_DATA_W-1:0] cfg_data;
	logic [PLHI_DATA_W-1:0] bare_in;
	logic [PLHI_DATA_W-1:0] bare_out;
	logic [PLHI_DATA_W-1:0] hs_in;
	logic hs_in_vld;
	logic hs_in_ack;
	logic [PLHI_DATA_W-1:0] hs_out;
	logic hs_out_vld;
	logic hs_out_ack;
	logic [PLHI_DATA_W-1:0] ao_in;
	logic ao_in_ack;
	logic [PLHI_DATA_W-1:0] ao_out;
	logic ao_out_ack;
	logic [PLHI_DATA_W-1:0] vo_in;
	logic vo_in_vld;
	logic [PLHI_DATA_W-1:0] vo_out;
	logic vo_out_vld;
	logic [PLHI_ADDR_W-1:0] ram_addr;
	logic ram_ce;
	logic ram_we;
	logic [PLHI_DATA_W-1:0] ram_write_data;
	logic [PLHI_DATA_W-1:0] ram_read_data;

	modport blk (
		input block_go, cfg_data, bare_in, hs_in, hs_in_vld, hs_out_ack,
		input ao_in, ao_out_ack, vo_in, vo_in_vld, ram_read_data,
		output bare_out, hs_in_ack, hs_out, hs_out_vld, ao_in_ack, ao_out,
		output vo_out, vo_out_vld, ram_addr, ram_ce, ram_we, ram_write_data
	);
	modport far (
		output block_go, cfg_data, bare_in, hs_in, hs_in_vld, hs_out_ack,
		output ao_in, ao_out_ack, vo_in, vo_in_vld, ram_read_data,
		input bare_out, hs_in_ack, hs_out, hs_out_vld, ao_in_ack, ao_out,
		input vo_out, vo_out_vld, ram_addr, ram_ce, ram_we, ram_write_data
	);
endinterface : plhi_if

// ===== logic/plhi_pkg.sv
// Shared constants and types for the port-level handshake block.
package plhi_pkg;
	localparam int PLHI_DATA_W = 16;
	localparam int PLHI_ADDR_W = 6;
	localparam int PLHI_RAM_LAT = 1;
	localparam int PLHI_ITEMS = 4;
	localparam logic [15:0] PLHI_DATA_RST = 16'h0000;
	localparam logic [5:0] PLHI_ADDR_RST = 6'h00;

	typedef enum logic [6:0] {
		PLHI_IDLE = 7'h01,
		PLHI_GET = 7'h02,
		PLHI_PUT = 7'h04,
		PLHI_RD = 7'h08,
		PLHI_RWAIT = 7'h10,
		PLHI_WR = 7'h20,
		PLHI_ACKOUT = 7'h40
	} plhi_state_t;
endpackage : plhi_pkg

// ===== verif/plhi_link_properties.sv
// Concurrent checks on the link between the two ends.
`timescale 1ns/100ps
module plhi_link_properties
	import plhi_pkg::*;
	(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Link signals.
	input wire logic hs_in_vld,
	input wire logic hs_in_ack,
	input wire logic [PLHI_DATA_W-1:0] hs_out,
	input wire logic hs_out_vld,
	input wire logic hs_out_ack,
	input wire logic ao_in_ack,
	input wire logic vo_out_vld,
	input wire logic [PLHI_ADDR_W-1:0] ram_addr,
	input wire logic ram_ce,
	input wire logic ram_we
	);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_rd;
		ram_ce && !ram_we;
	endsequence
	sequence s_wr;
		ram_ce && ram_we;
	endsequence
	AST_ACK_VLD: assert property (hs_in_ack |-> hs_in_vld)
		else $error("input ack without valid");
	AST_OUT_HOLD: assert property (hs_out_vld && !hs_out_ack
		|=> hs_out_vld && $stable(hs_out)) else $error("output not held");
	AST_OUT_DROP: assert property (hs_out_vld && hs_out_ack
		|=> !hs_out_vld) else $error("valid not dropped");
	AST_WE_CE: assert property (ram_we |-> ram_ce)
		else $error("write without chip enable");
	AST_RD_LAT: assert property (s_rd |=> ao_in_ack)
		else $error("read data not consumed");
	AST_CONSUME: assert property (ao_in_ack |-> $past(ram_ce)
		&& !$past(ram_we)) else $error("ack without read");
	AST_WR_ADDR: assert property (s_wr
		|=> ram_addr == $past(ram_addr) + 1'b1) else $error("address");
	AST_VO_ONE: assert property (vo_out_vld |=> !vo_out_vld)
		else $error("valid output too long");
	AST_OUT_RISE: assert property ($rose(hs_out_vld)
		|-> vo_out_vld && $past(ram_we)) else $error("valid late");
endmodule : plhi_link_properties

// ===== verif/tb.sv
// Self-checking bench joining block end and far end.
`timescale 1ns/100ps
module tb;
	import plhi_pkg::*;
	typedef struct {int vdly; int rdly; int npass; logic [15:0] res;}
		plhi_row_t;
	logic clk_sys, rst, go, src_vld, sink_rdy;
	logic [PLHI_DATA_W-1:0] cfg, src_data;
	logic busy, pass_done;
	int err_count, checks, n_ack, n_we, n_done, t;
	plhi_row_t rows [3] = '{'{0, 0, 1, 16'h0049}, '{5, 9, 1, 16'h0049},
		'{0, 0, 2, 16'h0049}};
	plhi_if lnk();
	plhi_block i_plhi_block (.clk_sys, .rst, .lnk(lnk.blk), .busy,
		.pass_done);
	plhi_far i_plhi_far (.clk_sys, .rst, .lnk(lnk.far), .go, .cfg,
		.src_data, .src_vld, .sink_rdy, .sink_data(), .sink_vld());
	plhi_link_properties i_props (.clk_sys, .rst,
		.hs_in_vld(lnk.hs_in_vld), .hs_in_ack(lnk.hs_in_ack),
		.hs_out(lnk.hs_out), .hs_out_vld(lnk.hs_out_vld),
		.hs_out_ack(lnk.hs_out_ack), .ao_in_ack(lnk.ao_in_ack),
		.vo_out_vld(lnk.vo_out_vld), .ram_addr(lnk.ram_addr),
		.ram_ce(lnk.ram_ce), .ram_we(lnk.ram_we));
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task check(input logic [15:0] seen, input logic [15:0] exp,
		input string nm);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task test_done;
		$display("mismatches %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	// Counting is done right after the edge, so pulses are seen once.
	task run(input plhi_row_t r);
		n_ack = 0;
		n_we = 0;
		n_done = 0;
		go <= 1'b1;
		src_vld <= (r.vdly == 0);
		sink_rdy <= (r.rdly == 0);
		for (t = 0; t < 300 && n_done < r.npass; t++)
		begin
			@(posedge clk_sys);
			n_ack += int'(lnk.hs_in_ack === 1'b1);
			n_we += int'(lnk.ram_we === 1'b1);
			n_done += int'(pass_done === 1'b1);
			if (t == r.vdly) src_vld <= 1'b1;
			if (t == r.rdly) sink_rdy <= 1'b1;
			if (busy === 1'b1 && n_done == r.npass - 1) go <= 1'b0;
		end
		if (t == 300)
		begin
			err_count++;
			test_done();
		end
		src_vld <= 1'b0;
		sink_rdy <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check(16'(n_ack), 16'(r.npass), "input acks");
		check(16'(n_we), 16'(r.npass), "ram writes");
		check({15'h0000, busy}, 16'h0000, "busy after pass");
		check(lnk.bare_out, r.res, "bare output");
		check(lnk.hs_out, r.res, "handshake output");
		check(lnk.vo_out, r.res, "valid-only output");
	endtask : run
	initial
	begin
		rst = 1'b1;
		go = 1'b0;
		src_vld = 1'b1;
		sink_rdy = 1'b1;
		cfg = 16'h0005;
		src_data = 16'h0011;
		err_count = 0;
		checks = 0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		n_ack = 0;
		repeat (10)
		begin
			@(posedge clk_sys);
			n_ack += int'(lnk.hs_in_ack === 1'b1 || busy === 1'b1);
		end
		check(16'(n_ack), 16'h0000, "activity without go");
		src_vld <= 1'b0;
		sink_rdy <= 1'b0;
		foreach (rows[i])
			run(rows[i]);
		// A reset in mid-pass must leave the link quiet.
		go <= 1'b1;
		src_vld <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b1;
		go <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check(16'({busy, lnk.ram_ce, lnk.hs_out_vld}), 16'h0000,
			"reset");
		run(rows[1]);
		test_done();
	end
endmodule : tb
